// *** serial_format_clock_select.sv ***
// Serial interface: mode and format select, clock source select, buffers, bus slave
`timescale 1ns/1ps
`include "serial_format_map.svh"
module serial_format_clock_select (
  input  logic                      mclk,
  input  logic                      rstn,
  input  serial_format_pkg::avreq_s avReq,
  output logic [31:0]               readdata,
  output logic                      waitrequest,
  output logic                      txd,
  input  logic                      rxd,
  input  logic                      sckIn,
  output logic                      sckOut,
  output logic                      sckOe
);
  import serial_format_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  mode_q, ctrl_q, div_q, baudCnt_q;
  logic [8:0]  txBuf_q;
  logic        txEmpty_q, txEnd_q, rxFull_q;
  rxres_s      rxBuf_q, rxRes;
  logic [3:0]  err_q, errSet, errClr, txPhase;
  logic        wait_q, sckOut_q, sckOe_q, intSck_q;
  logic [31:0] rdata_q, rdMux;
  logic        sckS1_q, sckS2_q, sckS3_q;
  fmt_s        fmt;
  logic        extClk, baudTick, extRise, extFall, run;
  logic        tick16, sckFall, sckRise, intFall, intRise;
  logic        wrEn, rdEn, txTaken, txBusy, rxDone, rxSet, rxClr;
  logic        txEn, rxEn, intSckD;

  ////////////////////////////////////////////////////////////////////////////////
  // Format decode from the mode register
  assign fmt.sync   = mode_q[`MODE_SYNC];
  assign fmt.char7  = mode_q[`MODE_CHAR7];
  assign fmt.parEn  = mode_q[`MODE_PAREN];
  assign fmt.parOdd = mode_q[`MODE_PARODD];
  assign fmt.stop2  = mode_q[`MODE_STOP2];
  assign fmt.mpEn   = mode_q[`MODE_MPEN];

  // Control decode
  assign extClk = ctrl_q[`CTRL_CKEHI];
  assign txEn   = ctrl_q[`CTRL_TXEN];
  assign rxEn   = ctrl_q[`CTRL_RXEN];

  // Outputs straight from flops
  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign sckOut      = sckOut_q;
  assign sckOe       = sckOe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes
  assign wrEn = !wait_q && avReq.write;
  assign rdEn = !wait_q && avReq.read;

  // Wait state sequencing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) wait_q <= 1'b1;
    else if (wait_q && (avReq.read || avReq.write)) wait_q <= 1'b0;
    else wait_q <= 1'b1;
  end

  // Read data mux
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (avReq.address)
      `OFS_MODE:   rdMux = {24'h00_0000, mode_q};
      `OFS_CTRL:   rdMux = {24'h00_0000, ctrl_q};
      `OFS_DIV:    rdMux = {24'h00_0000, div_q};
      `OFS_TXDATA: rdMux = {23'h00_0000, txBuf_q};
      `OFS_RXDATA: rdMux = {23'h00_0000, rxBuf_q.multiproc_bit, rxBuf_q.data};
      `OFS_STATUS: rdMux = {24'h00_0000, txEmpty_q, rxFull_q, err_q[3:1], txEnd_q,
                            err_q[0], rxd};
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle and held through completion
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_q <= 32'h0000_0000;
    else if (wait_q && avReq.read) rdata_q <= rdMux;
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `MODE_RST;
      ctrl_q <= `CTRL_RST;
      div_q  <= `DIV_RST;
    end else if (wrEn) begin
      if (avReq.address == `OFS_MODE) mode_q <= avReq.writedata[7:0];
      if (avReq.address == `OFS_CTRL) ctrl_q <= avReq.writedata[7:0];
      if (avReq.address == `OFS_DIV) div_q <= avReq.writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock sources
  // Pin clock synchroniser; edges taken from the second and third stages
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sckS1_q <= 1'b1;
      sckS2_q <= 1'b1;
      sckS3_q <= 1'b1;
    end else begin
      sckS1_q <= sckIn;
      sckS2_q <= sckS1_q;
      sckS3_q <= sckS2_q;
    end
  end
  assign extRise = sckS2_q && !sckS3_q;
  assign extFall = !sckS2_q && sckS3_q;

  // Bit-rate generator: one tick every div_q+1 cycles
  assign baudTick = (baudCnt_q == div_q);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) baudCnt_q <= 8'h00;
    else if (baudTick) baudCnt_q <= 8'h00;
    else baudCnt_q <= baudCnt_q + 8'h01;
  end

  // Internal sync clock runs only while a character is in flight, idles high
  assign run     = txBusy || (rxEn && !txEn && !rxFull_q);
  assign intFall = baudTick && intSck_q && run;
  assign intRise = baudTick && !intSck_q;
  // Next value of the internal clock, so the pin copy stays in phase with the shifters
  always_comb begin
    intSckD = intSck_q;
    if (!fmt.sync) intSckD = 1'b1;
    else if (intFall || intRise) intSckD = !intSck_q;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) intSck_q <= 1'b1;
    else intSck_q <= intSckD;
  end

  // Strobe selection for the shifters
  assign tick16  = !fmt.sync && (extClk ? extRise : baudTick);
  assign sckFall = fmt.sync && (extClk ? extFall : intFall);
  assign sckRise = fmt.sync && (extClk ? extRise : intRise);

  // Clock pin drive: sync internal always, async internal only when asked
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sckOe_q  <= 1'b0;
      sckOut_q <= 1'b1;
    end else begin
      sckOe_q  <= !extClk && (fmt.sync || ctrl_q[`CTRL_CKELO]);
      sckOut_q <= fmt.sync ? intSckD : txPhase[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit side
  serial_tx u_tx (
    .mclk      (mclk),
    .rstn      (rstn),
    .fmt       (fmt),
    .en        (txEn),
    .tick16    (tick16),
    .sckFall   (sckFall),
    .sckRise   (sckRise),
    .loadValid (!txEmpty_q),
    .loadData  (txBuf_q),
    .loadTaken (txTaken),
    .busy      (txBusy),
    .txd       (txd),
    .phase     (txPhase)
  );

  // Transmit holding register; a new write wins over the shifter taking it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txBuf_q   <= 9'h000;
      txEmpty_q <= 1'b1;
      txEnd_q   <= 1'b1;
    end else begin
      txEnd_q <= txEmpty_q && !txBusy;
      if (wrEn && avReq.address == `OFS_TXDATA) begin
        txBuf_q   <= avReq.writedata[8:0];
        txEmpty_q <= 1'b0;
      end else if (txTaken) begin
        txEmpty_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive side
  serial_rx u_rx (
    .mclk    (mclk),
    .rstn    (rstn),
    .fmt     (fmt),
    .en      (rxEn),
    .tick16  (tick16),
    .sckRise (sckRise),
    .rxd     (rxd),
    .done    (rxDone),
    .res     (rxRes)
  );

  // Error events: overrun, framing, parity, break
  always_comb begin
    errSet = 4'h0;
    rxSet  = 1'b0;
    if (rxDone) begin
      if (rxFull_q) begin
        errSet[3] = 1'b1;
      end else if (!fmt.sync && (rxRes.frmErr || rxRes.parErr)) begin
        errSet[2] = rxRes.frmErr;
        errSet[1] = rxRes.parErr;
        errSet[0] = rxRes.frmErr && rxRes.data == 8'h00 && !rxd;
      end else begin
        rxSet = 1'b1;
      end
    end
  end

  // Status write clears: one bits clear, break goes with framing
  assign errClr = (wrEn && avReq.address == `OFS_STATUS) ?
                  {avReq.writedata[5], avReq.writedata[4], avReq.writedata[3],
                   avReq.writedata[4] | avReq.writedata[1]} : 4'h0;
  assign rxClr  = rdEn && avReq.address == `OFS_RXDATA;

  // Receive holding register and flags; a set wins over a clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxBuf_q  <= '0;
      rxFull_q <= 1'b0;
      err_q    <= 4'h0;
    end else begin
      err_q    <= (err_q & ~errClr) | errSet;
      rxFull_q <= (rxFull_q && !rxClr) || rxSet;
      if (rxDone && !rxFull_q) rxBuf_q <= rxRes;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sync_errors: assert property (@(posedge mclk) disable iff (!rstn)
    (rxDone && fmt.sync) |=> !($rose(err_q[2]) || $rose(err_q[1])))
    else $error("framing or parity flagged in sync mode");
  a_pin_unused: assert property (@(posedge mclk) disable iff (!rstn)
    (!fmt.sync && !extClk && !ctrl_q[`CTRL_CKELO]) |=> !sckOe_q)
    else $error("clock pin driven while unused");
  a_pin_bitclk: assert property (@(posedge mclk) disable iff (!rstn)
    (!fmt.sync && !extClk && ctrl_q[`CTRL_CKELO]) |=> sckOe_q)
    else $error("bit clock not driven");
  a_sync_drive: assert property (@(posedge mclk) disable iff (!rstn)
    (fmt.sync && !extClk) |=> sckOe_q) else $error("sync clock not driven");
  a_ext_input: assert property (@(posedge mclk) disable iff (!rstn)
    extClk |=> !sckOe_q) else $error("pin driven with external clock");
  a_clock_phase: assert property (@(posedge mclk) disable iff (!rstn)
    (!fmt.sync && !$past(fmt.sync) && !$past(fmt.sync, 2) && $rose(sckOut_q))
    |-> ($past(txPhase) == `PHASE_MID)) else $error("output clock off bit centre");
  a_overrun_keep: assert property (@(posedge mclk) disable iff (!rstn)
    (rxDone && rxFull_q) |=> (err_q[3] && $stable(rxBuf_q)))
    else $error("overrun lost or buffer overwritten");
  a_bus_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (wait_q && (avReq.read || avReq.write)) |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle");
endmodule : serial_format_clock_select

// *** serial_format_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_FORMAT_MAP_SVH
`define SERIAL_FORMAT_MAP_SVH
`define OFS_MODE    5'h00
`define OFS_CTRL    5'h04
`define OFS_DIV     5'h08
`define OFS_TXDATA  5'h0C
`define OFS_RXDATA  5'h10
`define OFS_STATUS  5'h14
`define MODE_SYNC   7
`define MODE_CHAR7  6
`define MODE_PAREN  5
`define MODE_PARODD 4
`define MODE_STOP2  3
`define MODE_MPEN   2
`define CTRL_TXEN   5
`define CTRL_RXEN   4
`define CTRL_CKEHI  1
`define CTRL_CKELO  0
`define MODE_RST    8'h00
`define CTRL_RST    8'h00
`define DIV_RST     8'hFF
`define TICKS_LAST  4'hF
`define MID_TICK    4'h7
`define SYNC_LAST   4'h7
`define PHASE_MID   4'h8
`endif

// *** serial_format_pkg.sv ***
// Types shared by the serial format and clock select block
package serial_format_pkg;
  typedef struct packed {
    logic sync;
    logic char7;
    logic parEn;
    logic parOdd;
    logic stop2;
    logic mpEn;
  } fmt_s;
  typedef struct packed {
    logic [7:0] data;
    logic       multiproc_bit;
    logic       parErr;
    logic       frmErr;
  } rxres_s;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } avreq_s;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} txst_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxst_e;
endpackage : serial_format_pkg

// *** serial_tx.sv ***
// Transmit shifter with frame assembly
`timescale 1ns/1ps
`include "serial_format_map.svh"
module serial_tx (
  input  logic                    mclk,
  input  logic                    rstn,
  input  serial_format_pkg::fmt_s fmt,
  input  logic                    en,
  input  logic                    tick16,
  input  logic                    sckFall,
  input  logic                    sckRise,
  input  logic                    loadValid,
  input  logic [8:0]              loadData,
  output logic                    loadTaken,
  output logic                    busy,
  output logic                    txd,
  output logic [3:0]              phase
);
  import serial_format_pkg::*;
  txst_e       state_q;
  logic [10:0] shift_q;
  logic [3:0]  cnt_q, last_q, lastD, dlen, phase_q;
  logic [11:0] frameD;
  logic [7:0]  dm;
  logic        extra, bnd, endBit, load, txd_q, armed_q;

  // Frame assembly from the selected format
  always_comb begin
    frameD = 12'hFFF;
    dlen   = fmt.char7 ? 4'h7 : 4'h8;
    extra  = fmt.parEn | fmt.mpEn;
    dm     = fmt.char7 ? {1'b0, loadData[6:0]} : loadData[7:0];
    lastD  = `SYNC_LAST;
    if (fmt.sync) begin
      frameD = {4'hF, loadData[7:0]};
    end else begin
      frameD[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < dlen) frameD[i+1] = loadData[i];
      end
      if (extra) frameD[dlen+4'h1] = fmt.mpEn ? loadData[8] : ((^dm) ^ fmt.parOdd);
      lastD = dlen + {3'h0, extra} + {3'h0, fmt.stop2} + 4'h1;
    end
  end

  assign bnd       = fmt.sync ? (sckFall && armed_q) : (tick16 && phase_q == `TICKS_LAST);
  assign endBit    = (state_q == TX_SHIFT) && cnt_q == last_q && (fmt.sync ? sckRise : bnd);
  assign load      = en && loadValid &&
                     ((state_q == TX_IDLE) ? (fmt.sync || bnd) : (endBit && !fmt.sync));
  assign loadTaken = load;
  assign busy      = (state_q == TX_SHIFT);
  assign txd       = txd_q;
  assign phase     = phase_q;

  // Free-running 16x phase, also used for the output bit clock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) phase_q <= 4'h0;
    else if (tick16) phase_q <= phase_q + 4'h1;
  end

  // Shifter, least significant bit first
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= TX_IDLE;
      shift_q <= 11'h7FF;
      cnt_q   <= 4'h0;
      last_q  <= 4'h0;
      txd_q   <= 1'b1;
      armed_q <= 1'b0;
    end else if (load) begin
      state_q <= TX_SHIFT;
      txd_q   <= frameD[0];
      shift_q <= frameD[11:1];
      cnt_q   <= 4'h0;
      last_q  <= lastD;
      armed_q <= 1'b0;
    end else if (endBit) begin
      // Sync holds the last bit past its sampling rise, mark follows a cycle later
      state_q <= TX_IDLE;
      if (!fmt.sync) txd_q <= 1'b1;
    end else if (state_q == TX_IDLE) begin
      txd_q   <= 1'b1;
    end else if (state_q == TX_SHIFT) begin
      if (sckRise) armed_q <= 1'b1;
      if (bnd) begin
        txd_q   <= shift_q[0];
        shift_q <= {1'b1, shift_q[10:1]};
        cnt_q   <= cnt_q + 4'h1;
        armed_q <= 1'b0;
      end
    end
  end

  a_idle_mark: assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == TX_IDLE && $past(state_q) == TX_IDLE) |-> txd_q)
    else $error("line not at mark while idle");
  a_start_low: assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == TX_SHIFT && cnt_q == 4'h0 && !fmt.sync) |-> !txd_q)
    else $error("start bit not low");
  a_sync_eight: assert property (@(posedge mclk) disable iff (!rstn)
    (load && fmt.sync) |=> (last_q == 4'h7 && busy)) else $error("sync frame not 8 bits");
endmodule : serial_tx

// *** serial_rx.sv ***
// Receive sampler and deframer
`timescale 1ns/1ps
`include "serial_format_map.svh"
module serial_rx (
  input  logic                      mclk,
  input  logic                      rstn,
  input  serial_format_pkg::fmt_s   fmt,
  input  logic                      en,
  input  logic                      tick16,
  input  logic                      sckRise,
  input  logic                      rxd,
  output logic                      done,
  output serial_format_pkg::rxres_s res
);
  import serial_format_pkg::*;
  rxst_e      state_q;
  logic [3:0] tc_q, idx_q, nBits;
  logic [8:0] sh_q, shIn, al;
  logic [7:0] dat;
  logic       lvl_q, done_q, sample, xb;
  rxres_s     res_q;

  // Bit count, alignment and checks
  assign nBits  = fmt.sync ? 4'h8 : ((fmt.char7 ? 4'h7 : 4'h8) + {3'h0, fmt.parEn | fmt.mpEn});
  assign sample = fmt.sync ? sckRise : (tick16 && tc_q == `TICKS_LAST);
  assign shIn   = fmt.sync ? {rxd, sh_q[8:1]} : sh_q;
  assign al     = shIn >> (4'h9 - nBits);
  assign dat    = fmt.char7 ? {1'b0, al[6:0]} : al[7:0];
  assign xb     = fmt.char7 ? al[7] : al[8];
  assign done   = done_q;
  assign res    = res_q;

  // Line level seen on the previous sampling pulse
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lvl_q <= 1'b1;
    else if (tick16) lvl_q <= rxd;
  end

  // Receive sequence
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RX_IDLE;
      tc_q    <= 4'h0;
      idx_q   <= 4'h0;
      sh_q    <= 9'h000;
      done_q  <= 1'b0;
      res_q   <= '0;
    end else begin
      done_q <= 1'b0;
      if (tick16) tc_q <= tc_q + 4'h1;
      if (!en) begin
        state_q <= RX_IDLE;
      end else begin
        unique case (state_q)
          RX_IDLE: begin
            idx_q <= 4'h0;
            if (fmt.sync) state_q <= RX_DATA;
            else if (tick16 && lvl_q && !rxd) begin
              state_q <= RX_START;
              tc_q    <= 4'h0;
            end
          end
          RX_START: begin
            if (tick16 && tc_q == `MID_TICK) begin
              state_q <= rxd ? RX_IDLE : RX_DATA;
              tc_q    <= 4'h0;
            end
          end
          RX_DATA: begin
            if (sample) begin
              sh_q  <= {rxd, sh_q[8:1]};
              idx_q <= idx_q + 4'h1;
              if (idx_q == nBits - 4'h1) begin
                state_q <= fmt.sync ? RX_IDLE : RX_STOP;
                if (fmt.sync) begin
                  done_q <= 1'b1;
                  res_q  <= '{data: al[7:0], multiproc_bit: 1'b0, parErr: 1'b0, frmErr: 1'b0};
                end
              end
            end
          end
          RX_STOP: begin
            if (sample) begin
              state_q      <= RX_IDLE;
              done_q       <= 1'b1;
              res_q.data   <= dat;
              res_q.multiproc_bit    <= fmt.mpEn & xb;
              res_q.parErr <= fmt.parEn && !fmt.mpEn && (((^dat) ^ xb) != fmt.parOdd);
              res_q.frmErr <= !rxd;
            end
          end
        endcase
      end
    end
  end

  a_start_align: assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == RX_IDLE && en && !fmt.sync && tick16 && lvl_q && !rxd)
    |=> (state_q == RX_START && tc_q == 4'h0)) else $error("start edge not aligned");
  a_mid_sample: assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == RX_START && $changed(state_q) == 1'b0 && tick16 && tc_q < 4'h7 && en)
    |=> (state_q == RX_START)) else $error("start checked before mid pulse");
  a_mp_noparity: assert property (@(posedge mclk) disable iff (!rstn)
    (done_q && $past(fmt.mpEn)) |-> !res_q.parErr) else $error("parity flagged in mp format");
endmodule : serial_rx

// *** serial_peer.sv ***
// Remote serial peer: captures and sends frames on the serial pins
`timescale 1ns/1ps
module serial_peer (
  input  wire logic mclk,
  input  wire logic txd,
  input  wire logic sckOut,
  output logic      rxd,
  output logic      sckIn
);
  logic [15:0] got;
  int          per = 16;
  // Line idles at mark, external clock input held low until extClock toggles it
  initial begin
    rxd = 1'b1;
    sckIn = 1'b0;
  end
  // Align to the start edge, then sample each bit centre
  task automatic capAsync(input int n);
    got = '0;
    @(negedge txd);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      got[i] = txd;
      if (i < n - 1) repeat (per) @(posedge mclk);
    end
  endtask : capAsync
  // External clock at sixteen times the bit rate, one toggle per mclk
  task automatic extClock(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      sckIn <= ~sckIn;
    end
  endtask : extClock
  // Clocked capture on each rising serial clock
  task automatic capSync();
    got = '0;
    for (int i = 0; i < 8; i++) begin
      @(posedge sckOut);
      got[i] = txd;
    end
  endtask : capSync
  // Send a frame, 16 clocks per bit, then back to mark
  task automatic sendAsync(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (16) @(posedge mclk);
    end
    rxd <= 1'b1;
  endtask : sendAsync
endmodule : serial_peer

// *** serial_format_clock_select_test.sv ***
// Self-checking bench for the serial format and clock select block
`timescale 1ns/1ps
`include "serial_format_map.svh"
module serial_format_clock_select_test;
  import serial_format_pkg::*;
  logic        mclk, rstn, waitrequest, txd, rxd, sckIn, sckOut, sckOe;
  avreq_s      avReq;
  logic [31:0] readdata, rd;
  logic [15:0] fr;
  int          n;
  int          bad_count = 0;
  int          cmp_count = 0;
  serial_format_clock_select uut (.mclk(mclk), .rstn(rstn), .avReq(avReq), .readdata(readdata),
    .waitrequest(waitrequest), .txd(txd), .rxd(rxd), .sckIn(sckIn), .sckOut(sckOut),
    .sckOe(sckOe));
  serial_peer peer (.mclk(mclk), .txd(txd), .sckOut(sckOut), .rxd(rxd), .sckIn(sckIn));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus access held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    avReq <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) bad_count++;
    rd = readdata;
    avReq <= '0;
  endtask : acc
  // Poll status until a flag shows
  task automatic waitStat(input logic [31:0] mask);
    int k;
    k = 0;
    do begin
      acc(1'b0, `OFS_STATUS, '0);
      k++;
    end while ((rd & mask) == 0 && k < 400);
    chk(rd & mask, mask);
  endtask : waitStat
  // Reprogram format with both directions stopped first
  task automatic setMode(input logic [7:0] m, input logic [31:0] c);
    acc(1'b1, `OFS_CTRL, '0);
    acc(1'b1, `OFS_MODE, {24'h0, m});
    acc(1'b1, `OFS_CTRL, c);
  endtask : setMode
  // Expected async frame: start, data, parity or mp bit, stops
  function automatic logic [15:0] frame(input logic [7:0] m, input logic [8:0] d, output int n);
    logic p;
    frame = '0;
    n = 1;
    p = m[4];
    for (int i = 0; i < (m[6] ? 7 : 8); i++) begin
      frame[n] = d[i];
      p = p ^ d[i];
      n++;
    end
    if (m[2] || m[5]) begin
      frame[n] = m[2] ? d[8] : p;
      n++;
    end
    frame[n] = 1'b1;
    n = n + 1 + int'(m[3]);
    frame[n - 1] = 1'b1;
  endfunction : frame
  // One transmitted frame in a given format
  task automatic txCase(input logic [7:0] m, input logic [8:0] d);
    setMode(m, 32'h30);
    fr = frame(m, d, n);
    fork
      peer.capAsync(n);
      acc(1'b1, `OFS_TXDATA, {23'h0, d});
    join
    chk(peer.got, fr);
  endtask : txCase
  // Closing verdict
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    avReq = '0;
    repeat (3) @(posedge mclk);
    chk({waitrequest, txd, sckOe}, 3'b110);
    rstn <= 1'b1;
    acc(1'b0, `OFS_MODE, '0);
    chk(rd, 32'h0);
    acc(1'b0, `OFS_DIV, '0);
    chk(rd, 32'hFF);
    acc(1'b0, 5'h18, '0);
    chk(rd, 32'h0);
    acc(1'b1, `OFS_DIV, '0);
    for (int i = 0; i < 12; i++) begin
      txCase({1'b0, i[0], i[3:2] == 2'd1, i[1], i[1], i[3:2] == 2'd2, 2'b00}, 9'(i * 37) + 9'h1A5);
    end
    setMode(8'h00, 32'h30);
    fork
      peer.capAsync(10);
      begin
        acc(1'b1, `OFS_TXDATA, 32'hF0);
        waitStat(32'h80);
        acc(1'b1, `OFS_TXDATA, 32'hCC);
      end
    join
    chk(peer.got, 16'h03E0);
    peer.capAsync(10);
    chk(peer.got, 16'h0398);
    fr = frame(8'h00, 9'h0A5, n);
    fork
      peer.sendAsync(fr, n);
      peer.capAsync(10);
      acc(1'b1, `OFS_TXDATA, 32'h3C);
    join
    chk(peer.got, 16'h0278);
    waitStat(32'h40);
    acc(1'b0, `OFS_RXDATA, '0);
    chk(rd, 32'hA5);
    fr = frame(8'h00, 9'h05A, n);
    fr[9] = 1'b0;
    peer.sendAsync(fr, n);
    acc(1'b0, `OFS_STATUS, '0);
    chk(rd[6:4], 3'b001);
    acc(1'b1, `OFS_STATUS, 32'h38);
    setMode(8'h20, 32'h30);
    fr = frame(8'h20, 9'h033, n);
    fr[9] = ~fr[9];
    peer.sendAsync(fr, n);
    acc(1'b0, `OFS_STATUS, '0);
    chk(rd[6:3], 4'b0001);
    setMode(8'h00, 32'h32);
    peer.per = 32;
    fork
      peer.extClock(480);
      peer.capAsync(10);
      acc(1'b1, `OFS_TXDATA, 32'h5A);
    join
    chk(peer.got, 16'h02B4);
    chk(sckOe, 1'b0);
    peer.per = 16;
    setMode(8'h00, 32'h31);
    repeat (2) @(posedge mclk);
    chk(sckOe, 1'b1);
    setMode(8'h00, 32'h30);
    repeat (2) @(posedge mclk);
    chk(sckOe, 1'b0);
    setMode(8'hFC, 32'h20);
    repeat (2) @(posedge mclk);
    chk(sckOe, 1'b1);
    fork
      peer.capSync();
      acc(1'b1, `OFS_TXDATA, 32'h1C3);
    join
    chk(peer.got, 16'h00C3);
    finish_test();
  end
endmodule : serial_format_clock_select_test
